// ---- pch_pkg.sv ----
// constants, register layout and helpers for the pci configuration header bank
// assumes byte-addressed configuration accesses carried as aligned dwords
// Functional notes
// - latency timer is a writable 8-bit count of clocks in bits 15..8
// - counter starts from zero upward when we assert frame as initiator
// - count reached before our transfer ends: finish once grant is withdrawn
// - writable 8-bit line size in bits 7..0 sizes line-type memory bursts
// - timer/line register at offset 0Ch, resets to zero, all 16 bits writable
// - self-test field, bits 15..8 at 0Eh, always reads zero
// - layout type field, bits 7..0 at 0Eh, always reads zero
// - layout/self-test register at offset 0Eh is read-only
// - window base reads FFFFF800 after all ones are written
// - window base bits 31..11 writable, hold the upper base address bits
// - window size bits 10..4 always read zero, meaning 2 Kbytes
// - bit 3 reads zero, window is not prefetchable
// - bits 2..1 read zero, 32-bit base placeable anywhere
// - bit 0 reads zero, window lives in memory space
// - window base at 10h resets to zero and decodes the register window
package pch_pkg;
   // register byte offsets
   localparam logic [7:0]  OFS_TENURE     = 8'h0C;
   localparam logic [7:0]  OFS_LAYOUT     = 8'h0E;
   localparam logic [7:0]  OFS_WINDOW     = 8'h10;
   // field positions
   localparam int          LAT_LSB        = 8;
   localparam int          LINE_LSB       = 0;
   localparam int          LAYOUT_LSB     = 16;
   localparam int          WIN_PTR_LSB    = 11;
   // reset and fixed values
   localparam logic [15:0] TENURE_RST     = 16'h0000;
   localparam logic [15:0] LAYOUT_VAL     = 16'h0000;
   localparam logic [20:0] WIN_PTR_RST    = 21'h000000;
   localparam logic [10:0] WIN_LOW_VAL    = 11'h000;
   localparam logic [31:0] WIN_ONES_READ  = 32'hFFFFF800;
   // bus commands that move whole cache lines, and the all-lanes byte enable
   localparam logic [3:0]  CMD_MEM_RD_MUL = 4'hC;
   localparam logic [3:0]  CMD_MEM_RD_LN  = 4'hE;
   localparam logic [3:0]  CMD_MEM_WR_INV = 4'hF;
   localparam logic [3:0]  BE_ALL_N       = 4'h0;

   // line-type commands take their length from the line size
   function automatic logic is_line_cmd(input logic [3:0] cmd);
      return (cmd == CMD_MEM_RD_MUL) || (cmd == CMD_MEM_RD_LN) || (cmd == CMD_MEM_WR_INV);
   endfunction : is_line_cmd

   // true when a dword access selects the dword holding this byte offset
   function automatic logic hits_dword(input logic [7:0] addr, input logic [7:0] ofs);
      return addr[7:2] == ofs[7:2];
   endfunction : hits_dword
endpackage : pch_pkg

// ---- pch_cfg_if.sv ----
// configuration values and initiator events shared among the bank's modules
// assumes one clock domain, driven by the top module
`timescale 1ns/1ps
interface pch_cfg_if;
   logic [7:0]  lat_value;
   logic [7:0]  line_len;
   logic [20:0] win_ptr;
   logic        frame_start;
   logic        frame_end;
   logic        lat_expired;

   modport bank   (output lat_value, output line_len, output win_ptr);
   modport timer  (input lat_value, input frame_start, input frame_end, output lat_expired);
   modport engine (input lat_value, input line_len, input lat_expired,
                   output frame_start, output frame_end);
   modport decode (input win_ptr);
endinterface : pch_cfg_if

// ---- pch_lat_timer.sv ----
// bus tenure counter for our own initiator transactions
// assumes frame_start and frame_end are one-cycle pulses from the engine
`timescale 1ns/1ps
module pch_lat_timer (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // configuration and events
   pch_cfg_if.timer  cfg
);
   logic [7:0] count_ff;
   logic       active_ff;

   // tenure window opens at frame and closes at the final data phase
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         active_ff <= 1'b0;
      end else if (cfg.frame_start) begin
         active_ff <= 1'b1;
      end else if (cfg.frame_end) begin
         active_ff <= 1'b0;
      end
   end

   // counts up from zero; saturates so a long burst never wraps back under
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count_ff <= 8'h00;
      end else if (cfg.frame_start) begin
         count_ff <= 8'h00;
      end else if (active_ff && (count_ff != 8'hFF)) begin
         count_ff <= count_ff + 8'h01;
      end
   end

   // a zero setting expires at once, as the bus expects
   assign cfg.lat_expired = active_ff && (count_ff >= cfg.lat_value);

   cnt_from_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      cfg.frame_start |=> (count_ff == 8'h00) ##1 (count_ff == 8'h01 || cfg.frame_end))
      else $error("tenure count did not start from zero");
endmodule : pch_lat_timer

// ---- pch_win_decode.sv ----
// matches memory addresses against the programmed register window base
// assumes addresses arrive with a one-cycle valid strobe
`timescale 1ns/1ps
module pch_win_decode (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // configuration
   pch_cfg_if.decode        cfg,
   // address to decode
   input  wire logic [31:0] mem_addr,
   input  wire logic        mem_valid,
   output logic             win_hit_ff
);
   // 2-Kbyte window: only the upper 21 bits take part
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         win_hit_ff <= 1'b0;
      end else begin
         win_hit_ff <= mem_valid && (mem_addr[31:pch_pkg::WIN_PTR_LSB] == cfg.win_ptr);
      end
   end

   win_hit_a: assert property (@(posedge core_clk) disable iff (rst)
      mem_valid && (mem_addr[31:11] == cfg.win_ptr) |=> win_hit_ff)
      else $error("window address not decoded");
endmodule : pch_win_decode

// ---- pch_top.sv ----
// configuration header bank: tenure/line register, layout register, window base,
// plus the initiator sequencer that honours tenure and line size
// assumes configuration strobes are one-cycle pulses and the bus is idle at grant
`timescale 1ns/1ps
module pch_top (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // configuration access
   input  wire logic        cfg_rd,
   input  wire logic        cfg_wr,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata_ff,
   output logic             cfg_ack_ff,
   // initiator requests from the controller core
   input  wire logic        mst_req,
   input  wire logic [3:0]  mst_cmd,
   input  wire logic [31:0] mst_addr,
   input  wire logic [7:0]  mst_words,
   output logic             mst_busy_ff,
   output logic             mst_done_ff,
   output logic [7:0]       mst_left_ff,
   // bus arbitration and control pins
   input  wire logic        gnt_n,
   input  wire logic        trdy_n,
   output logic             req_n_ff,
   output logic             frame_n_ff,
   output logic             frame_oe_ff,
   output logic             irdy_n_ff,
   output logic             irdy_oe_ff,
   output logic [3:0]       cbe_n_ff,
   output logic             cbe_oe_ff,
   output logic [31:0]      ad_ff,
   output logic             ad_oe_ff,
   // register window decode
   input  wire logic [31:0] mem_addr,
   input  wire logic        mem_valid,
   output logic             win_hit_ff
);
   typedef enum logic [2:0] {
      PCH_IDLE,
      PCH_ARB,
      PCH_ADDR,
      PCH_DATA,
      PCH_RELEASE
   } pch_state_t;

   pch_cfg_if cfg ();

   logic [7:0]  lat_value_ff;
   logic [7:0]  line_len_ff;
   logic [20:0] win_ptr_ff;
   pch_state_t  state_ff;
   logic [7:0]  remain_ff;
   logic [7:0]  req_len_ff;
   logic [3:0]  cmd_ff;
   logic [31:0] addr_ff;
   logic        last_ff;
   logic        start_ff;
   logic        end_ff;
   logic        sel_tenure;
   logic        sel_window;
   logic        preempt;
   logic        xfer;
   logic [31:0] read_word;

   // bank outputs onto the shared carrier
   assign cfg.lat_value   = lat_value_ff;
   assign cfg.line_len    = line_len_ff;
   assign cfg.win_ptr     = win_ptr_ff;
   assign cfg.frame_start = start_ff;
   assign cfg.frame_end   = end_ff;

   assign sel_tenure = pch_pkg::hits_dword(cfg_addr, pch_pkg::OFS_TENURE);
   assign sel_window = pch_pkg::hits_dword(cfg_addr, pch_pkg::OFS_WINDOW);

   // latency timer byte, lane 1 of the 0Ch dword
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lat_value_ff <= pch_pkg::TENURE_RST[15:8];
      end else if (cfg_wr && sel_tenure && cfg_be[1]) begin
         lat_value_ff <= cfg_wdata[pch_pkg::LAT_LSB +: 8];
      end
   end

   // line size byte, lane 0 of the 0Ch dword
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         line_len_ff <= pch_pkg::TENURE_RST[7:0];
      end else if (cfg_wr && sel_tenure && cfg_be[0]) begin
         line_len_ff <= cfg_wdata[pch_pkg::LINE_LSB +: 8];
      end
   end

   // window pointer; lanes 2..3 of the 0Ch dword hold the fixed layout word,
   // so a write there has no register to land in and is dropped
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         win_ptr_ff <= pch_pkg::WIN_PTR_RST;
      end else if (cfg_wr && sel_window) begin
         if (cfg_be[1]) begin
            win_ptr_ff[4:0] <= cfg_wdata[15:11];
         end
         if (cfg_be[2]) begin
            win_ptr_ff[12:5] <= cfg_wdata[23:16];
         end
         if (cfg_be[3]) begin
            win_ptr_ff[20:13] <= cfg_wdata[31:24];
         end
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      read_word = 32'h00000000;
      if (sel_tenure) begin
         read_word = {pch_pkg::LAYOUT_VAL, lat_value_ff, line_len_ff};
      end else if (sel_window) begin
         read_word = {win_ptr_ff, pch_pkg::WIN_LOW_VAL};
      end
   end

   // every access is acknowledged one cycle later, writes included
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_ack_ff   <= 1'b0;
         cfg_rdata_ff <= 32'h00000000;
      end else begin
         cfg_ack_ff   <= cfg_rd || cfg_wr;
         cfg_rdata_ff <= cfg_rd ? read_word : 32'h00000000;
      end
   end

   // tenure ran out and the arbiter took the grant away
   assign preempt = cfg.lat_expired && gnt_n && !last_ff;
   assign xfer    = (state_ff == PCH_DATA) && !trdy_n;

   // initiator sequencer: request, address phase, data phases, turnaround.
   // write data is outside this bank; ad is driven only during the address phase
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff    <= PCH_IDLE;
         req_n_ff    <= 1'b1;
         frame_n_ff  <= 1'b1;
         frame_oe_ff <= 1'b0;
         irdy_n_ff   <= 1'b1;
         irdy_oe_ff  <= 1'b0;
         cbe_n_ff    <= 4'h0;
         cbe_oe_ff   <= 1'b0;
         ad_ff       <= 32'h00000000;
         ad_oe_ff    <= 1'b0;
         remain_ff   <= 8'h00;
         req_len_ff  <= 8'h00;
         cmd_ff      <= 4'h0;
         addr_ff     <= 32'h00000000;
         last_ff     <= 1'b0;
         start_ff    <= 1'b0;
         end_ff      <= 1'b0;
         mst_busy_ff <= 1'b0;
         mst_done_ff <= 1'b0;
         mst_left_ff <= 8'h00;
      end else begin
         start_ff    <= 1'b0;
         end_ff      <= 1'b0;
         mst_done_ff <= 1'b0;
         case (state_ff)
            PCH_IDLE: begin
               frame_oe_ff <= 1'b0;
               irdy_oe_ff  <= 1'b0;
               cbe_oe_ff   <= 1'b0;
               if (mst_req) begin
                  state_ff    <= PCH_ARB;
                  req_n_ff    <= 1'b0;
                  mst_busy_ff <= 1'b1;
                  cmd_ff      <= mst_cmd;
                  addr_ff     <= mst_addr;
                  req_len_ff  <= (mst_words == 8'h00) ? 8'h01 : mst_words;
               end
            end
            PCH_ARB: begin
               if (!gnt_n) begin
                  state_ff    <= PCH_ADDR;
                  req_n_ff    <= 1'b1;
                  frame_n_ff  <= 1'b0;
                  frame_oe_ff <= 1'b1;
                  cbe_n_ff    <= cmd_ff;
                  cbe_oe_ff   <= 1'b1;
                  ad_ff       <= addr_ff;
                  ad_oe_ff    <= 1'b1;
                  start_ff    <= 1'b1;
                  // a zero line size falls back to the requested length
                  if (pch_pkg::is_line_cmd(cmd_ff) && (line_len_ff != 8'h00)) begin
                     remain_ff <= line_len_ff;
                  end else begin
                     remain_ff <= req_len_ff;
                  end
               end
            end
            PCH_ADDR: begin
               state_ff   <= PCH_DATA;
               irdy_n_ff  <= 1'b0;
               irdy_oe_ff <= 1'b1;
               ad_oe_ff   <= 1'b0;
               cbe_n_ff   <= pch_pkg::BE_ALL_N;
               if (remain_ff == 8'h01) begin
                  frame_n_ff <= 1'b1;
                  last_ff    <= 1'b1;
               end else begin
                  last_ff    <= 1'b0;
               end
            end
            PCH_DATA: begin
               if (xfer && last_ff) begin
                  state_ff    <= PCH_RELEASE;
                  irdy_n_ff   <= 1'b1;
                  end_ff      <= 1'b1;
                  mst_left_ff <= remain_ff - 8'h01;
               end else if (xfer) begin
                  remain_ff <= remain_ff - 8'h01;
                  if ((remain_ff == 8'h02) || preempt) begin
                     frame_n_ff <= 1'b1;
                     last_ff    <= 1'b1;
                  end
               end else if (preempt) begin
                  frame_n_ff <= 1'b1;
                  last_ff    <= 1'b1;
               end
            end
            PCH_RELEASE: begin
               // irdy was driven high last cycle and frame earlier; let go of frame, irdy and the byte enables now
               state_ff    <= PCH_IDLE;
               frame_oe_ff <= 1'b0;
               irdy_oe_ff  <= 1'b0;
               cbe_oe_ff   <= 1'b0;
               mst_busy_ff <= 1'b0;
               mst_done_ff <= 1'b1;
            end
            default: begin
               state_ff <= PCH_IDLE;
            end
         endcase
      end
   end

   pch_lat_timer u_lat_timer (
      .core_clk (core_clk),
      .rst      (rst),
      .cfg      (cfg.timer)
   );

   pch_win_decode u_win_decode (
      .core_clk   (core_clk),
      .rst        (rst),
      .cfg        (cfg.decode),
      .mem_addr   (mem_addr),
      .mem_valid  (mem_valid),
      .win_hit_ff (win_hit_ff)
   );

   lat_write_a: assert property (@(posedge core_clk) disable iff (rst)
      cfg_wr && sel_tenure && cfg_be[1] |=> lat_value_ff == $past(cfg_wdata[15:8]))
      else $error("latency byte not stored");

   line_write_a: assert property (@(posedge core_clk) disable iff (rst)
      cfg_wr && sel_tenure && cfg_be[0] |=> line_len_ff == $past(cfg_wdata[7:0]))
      else $error("line size byte not stored");

   tenure_reset_a: assert property (@(posedge core_clk)
      $fell(rst) |-> (lat_value_ff == 8'h00) && (line_len_ff == 8'h00) && (win_ptr_ff == 21'h0))
      else $error("bank not at reset value");

   layout_fixed_a: assert property (@(posedge core_clk) disable iff (rst)
      cfg_rd && sel_tenure |=> cfg_ack_ff && (cfg_rdata_ff[31:16] == 16'h0000))
      else $error("layout word not zero");

   win_low_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      cfg_rd && sel_window |=> cfg_ack_ff && (cfg_rdata_ff[10:0] == 11'h000))
      else $error("window low bits not zero");

   win_ones_a: assert property (@(posedge core_clk) disable iff (rst)
      (cfg_wr && sel_window && (cfg_be == 4'hF) && (cfg_wdata == 32'hFFFFFFFF))
      ##1 !cfg_wr ##1 (cfg_rd && sel_window && !cfg_wr) |=> cfg_rdata_ff == 32'hFFFFF800)
      else $error("window sizing readback wrong");

   preempt_end_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == PCH_DATA) && preempt |=> frame_n_ff && last_ff)
      else $error("tenure expiry did not end frame");

   line_burst_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == PCH_ARB) && !gnt_n && pch_pkg::is_line_cmd(cmd_ff) && (line_len_ff != 8'h00)
      |=> remain_ff == $past(line_len_ff))
      else $error("line burst not sized by line size");

   frame_start_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(frame_n_ff) |-> start_ff && (state_ff == PCH_ADDR))
      else $error("frame without tenure start");
endmodule : pch_top

// ---- pch_bus_partner.sv ----
// far side of the initiator port: arbiter grant and a target's ready
// assumes the testbench asks for grant withdrawal and wait states
`timescale 1ns/1ps
module pch_bus_partner (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // pins seen from the bank
   input  wire logic req_n_ff,
   input  wire logic frame_n_ff,
   input  wire logic irdy_n_ff,
   // behaviour controls from the testbench
   input  wire logic gnt_drop,
   input  wire logic slow,
   // answers
   output logic      gnt_n,
   output logic      trdy_n
);
   logic wait_ff;

   // drive on the falling edge so the bank samples settled pins
   always @(negedge core_clk or posedge rst) begin
      if (rst) begin
         gnt_n   <= 1'b1;
         trdy_n  <= 1'b1;
         wait_ff <= 1'b0;
      end else begin
         // grant follows the request and stays through the tenure unless withdrawn
         gnt_n   <= ~((~req_n_ff | ~frame_n_ff | ~irdy_n_ff) & ~gnt_drop);
         // released ready goes to its pull-up level, never holds a stale low
         wait_ff <= slow & ~wait_ff & ~irdy_n_ff;
         trdy_n  <= ~(~irdy_n_ff & ~(slow & ~wait_ff));
      end
   end
endmodule : pch_bus_partner

// ---- pci_config_header_regs_test.sv ----
// self-checking bench for the configuration header bank and its initiator
// assumes pch_top with the bus partner model on gnt_n and trdy_n
`timescale 1ns/1ps
module pci_config_header_regs_test;
   logic        core_clk  = 1'b0;
   logic        rst       = 1'b1;
   logic        cfg_rd    = 1'b0;
   logic        cfg_wr    = 1'b0;
   logic [7:0]  cfg_addr  = 8'h00;
   logic [3:0]  cfg_be    = 4'h0;
   logic [31:0] cfg_wdata = 32'h00000000;
   logic        mst_req   = 1'b0;
   logic [3:0]  mst_cmd   = 4'h0;
   logic [7:0]  mst_words = 8'h00;
   logic [31:0] mem_addr  = 32'h00000000;
   logic        mem_valid = 1'b0;
   logic        gnt_drop  = 1'b0;
   logic        slow      = 1'b0;
   logic [31:0] cfg_rdata_ff, ad_ff;
   logic [31:0] rd_seen, ad_seen;
   logic [7:0]  mst_left_ff;
   logic [3:0]  cbe_n_ff, cmd_seen;
   logic        cfg_ack_ff, mst_busy_ff, mst_done_ff, gnt_n, trdy_n, req_n_ff;
   logic        frame_n_ff, frame_oe_ff, irdy_n_ff, irdy_oe_ff, cbe_oe_ff;
   logic        ad_oe_ff, win_hit_ff;
   int          bad_count  = 0;
   int          num_checks = 0;
   int          phases     = 0;
   int          cyc        = 0;

   always #20 core_clk = ~core_clk;

   pch_top pch_top_inst (.core_clk(core_clk), .rst(rst), .cfg_rd(cfg_rd),
      .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_rdata_ff(cfg_rdata_ff), .cfg_ack_ff(cfg_ack_ff), .mst_req(mst_req),
      .mst_cmd(mst_cmd), .mst_addr(32'h40001000), .mst_words(mst_words),
      .mst_busy_ff(mst_busy_ff), .mst_done_ff(mst_done_ff), .mst_left_ff(mst_left_ff),
      .gnt_n(gnt_n), .trdy_n(trdy_n), .req_n_ff(req_n_ff), .frame_n_ff(frame_n_ff),
      .frame_oe_ff(frame_oe_ff), .irdy_n_ff(irdy_n_ff), .irdy_oe_ff(irdy_oe_ff),
      .cbe_n_ff(cbe_n_ff), .cbe_oe_ff(cbe_oe_ff), .ad_ff(ad_ff), .ad_oe_ff(ad_oe_ff),
      .mem_addr(mem_addr), .mem_valid(mem_valid), .win_hit_ff(win_hit_ff));

   pch_bus_partner pch_bus_partner_inst (.core_clk(core_clk), .rst(rst),
      .req_n_ff(req_n_ff), .frame_n_ff(frame_n_ff), .irdy_n_ff(irdy_n_ff),
      .gnt_drop(gnt_drop), .slow(slow), .gnt_n(gnt_n), .trdy_n(trdy_n));

   // count completed data phases and catch the command of each address phase
   always @(posedge core_clk) begin
      cyc++;
      if (irdy_oe_ff === 1'b1 && irdy_n_ff === 1'b0 && trdy_n === 1'b0) phases++;
      if (ad_oe_ff === 1'b1) begin
         cmd_seen = cbe_n_ff;
         ad_seen  = ad_ff;
      end
      if (cyc == 20000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one-cycle strobe; acknowledge and read data stand in the following cycle only,
   // then one idle cycle so a strobe is never driven twice in one time step
   task automatic cfg_acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d);
      cfg_wr    = wr;
      cfg_rd    = ~wr;
      cfg_addr  = a;
      cfg_be    = be;
      cfg_wdata = d;
      @(negedge core_clk);
      rd_seen = cfg_rdata_ff;
      chk("cfg_ack", 32'h1, {31'h0, cfg_ack_ff});
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      @(negedge core_clk);
   endtask : cfg_acc

   task automatic cfg_rd_chk(input logic [7:0] a, input logic [31:0] exp);
      cfg_acc(1'b0, a, 4'hF, 32'h0);
      chk("cfg_rdata", exp, rd_seen);
   endtask : cfg_rd_chk

   // one initiator transfer, optionally withdrawing grant once frame is out
   task automatic mst_run(input logic [3:0] cmd, input logic [7:0] words, input logic drop);
      int n;
      phases    = 0;
      mst_cmd   = cmd;
      mst_words = words;
      mst_req   = 1'b1;
      @(negedge core_clk);
      mst_req = 1'b0;
      chk("mst_busy", 32'h1, {31'h0, mst_busy_ff});
      n = 0;
      while (mst_done_ff !== 1'b1 && n < 300) begin
         if (drop && frame_n_ff === 1'b0) gnt_drop <= 1'b1;
         @(negedge core_clk);
         n++;
      end
      chk("mst_done", 32'h1, {31'h0, mst_done_ff});
      gnt_drop <= 1'b0;
   endtask : mst_run

   task automatic test_reset_values();
      cfg_rd_chk(8'h0C, 32'h00000000);
      cfg_rd_chk(8'h10, 32'h00000000);
      cfg_rd_chk(8'h20, 32'h00000000);
   endtask : test_reset_values

   task automatic test_tenure_line_reg();
      cfg_acc(1'b1, 8'h0C, 4'hF, 32'hFFFFA5C3);
      cfg_rd_chk(8'h0C, 32'h0000A5C3);
      cfg_acc(1'b1, 8'h0C, 4'h2, 32'hFFFF3CFF);
      cfg_rd_chk(8'h0C, 32'h00003CC3);
      cfg_acc(1'b1, 8'h0E, 4'hC, 32'h12340000);
      cfg_rd_chk(8'h0C, 32'h00003CC3);
   endtask : test_tenure_line_reg

   task automatic test_window();
      cfg_acc(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF);
      cfg_rd_chk(8'h10, 32'hFFFFF800);
      cfg_acc(1'b1, 8'h10, 4'hF, 32'h12345ABC);
      cfg_rd_chk(8'h10, 32'h12345800);
      cfg_acc(1'b1, 8'h20, 4'hF, 32'hFFFFFFFF);
      cfg_rd_chk(8'h20, 32'h00000000);
      // the top address of the window hits, the next block misses
      mem_addr  = 32'h12345FFF;
      mem_valid = 1'b1;
      @(negedge core_clk);
      mem_addr = 32'h12346000;
      chk("win_hit", 32'h1, {31'h0, win_hit_ff});
      @(negedge core_clk);
      mem_valid = 1'b0;
      chk("win_miss", 32'h0, {31'h0, win_hit_ff});
   endtask : test_window

   task automatic test_line_cmds();
      logic [3:0] cmds [3];
      cmds = '{4'hC, 4'hE, 4'hF};
      cfg_acc(1'b1, 8'h0C, 4'hF, 32'h0000FF04);
      slow <= 1'b1;
      // each line command moves exactly one line of four words though a single word is asked
      foreach (cmds[i]) begin
         mst_run(cmds[i], 8'h01, 1'b0);
         chk("phases", 32'd4, 32'(phases));
         chk("cmd", {28'h0, cmds[i]}, {28'h0, cmd_seen});
         chk("addr", 32'h40001000, ad_seen);
         chk("left", 32'h0, {24'h0, mst_left_ff});
      end
      slow <= 1'b0;
      mst_run(4'h7, 8'h03, 1'b0);
      chk("phases", 32'd3, 32'(phases));
      cfg_acc(1'b1, 8'h0C, 4'h1, 32'h00000000);
      mst_run(4'hE, 8'h02, 1'b0);
      chk("phases", 32'd2, 32'(phases));
   endtask : test_line_cmds

   task automatic test_tenure_expiry();
      cfg_acc(1'b1, 8'h0C, 4'hF, 32'h00000200);
      // expired count alone must not end a transfer while grant is held
      mst_run(4'h7, 8'h08, 1'b0);
      chk("phases", 32'd8, 32'(phases));
      chk("left", 32'h0, {24'h0, mst_left_ff});
      mst_run(4'h7, 8'h08, 1'b1);
      chk("cut_short", 32'h1, {31'h0, phases < 8});
      chk("left", 32'(8 - phases), {24'h0, mst_left_ff});
   endtask : test_tenure_expiry

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   // reset for sixteen cycles, then each scenario in turn
   initial begin
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      test_reset_values();
      test_tenure_line_reg();
      test_window();
      test_line_cmds();
      test_tenure_expiry();
      finish_test();
   end
endmodule : pci_config_header_regs_test
